// *** verilog/fgr_defines.vh ***
/*
  Constants for the follower gearing block: source codes, ratio limits,
  home states, velocity sample window and ramp constants.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FGR_DEFINES_VH
`define FGR_DEFINES_VH

// ----------------------------------------------------------------
// Master source select codes
// ----------------------------------------------------------------
`define FGR_SRC_AUX_OR_INT 2'h0
`define FGR_SRC_ANALOG 2'h1
`define FGR_SRC_SECOND_SERVO 2'h2

// ----------------------------------------------------------------
// Ratio magnitude limits, 32:1 and 1:10000
// ----------------------------------------------------------------
`define FGR_RATIO_MAX_NUM 32'sd32
`define FGR_RATIO_MIN_DEN 32'sd10000

// ----------------------------------------------------------------
// Velocity sample window: 1 ms at 20 MHz
// ----------------------------------------------------------------
`define FGR_VEL_WINDOW_NS 1000000
`define FGR_CLK_PERIOD_NS 50
`define FGR_VEL_WINDOW_CYC (`FGR_VEL_WINDOW_NS / `FGR_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Home cycle states
// ----------------------------------------------------------------
`define FGR_HOME_IDLE 1'b0
`define FGR_HOME_WAIT 1'b1

// ----------------------------------------------------------------
// Engage states
// ----------------------------------------------------------------
`define FGR_ENG_OFF 2'h0
`define FGR_ENG_ARMED 2'h1
`define FGR_ENG_ON 2'h2

// ----------------------------------------------------------------
// Fraction bits of the ramped follower velocity
// ----------------------------------------------------------------
`define FGR_RAMP_FRAC 8
`endif

// *** verilog/fgr_ratio_scaler.v ***
/*
  Ratio scaler: turns a signed master count step per cycle into a slave
  step using A/B, keeping the remainder between steps.
  Assumes den_in stays from 1 to 32767 (validated upstream).
*/
`timescale 1ns/10ps
module fgr_ratio_scaler
(
  input wire sys_clk_in,                 // Module clock
  input wire rst_b_in,                   // Sync reset, active low
  input wire signed [7:0] master_step_in,   // Master counts this cycle
  input wire signed [15:0] num_in,       // Ratio numerator A
  input wire signed [15:0] den_in,       // Ratio denominator B
  output reg signed [15:0] slave_step_out   // Scaled slave step
);

  reg signed [31:0] rem_r;
  reg signed [31:0] acc;
  reg signed [31:0] quo;
  reg signed [31:0] den_w;

  // ----------------------------------------------------------------
  // Floor division with carried remainder
  // ----------------------------------------------------------------
  always @*
  begin
    den_w = {{16{den_in[15]}}, den_in};
    // Carry at or above a new, smaller B is dropped, not paid out
    acc = ((rem_r < den_w) ? rem_r : 32'sd0) +
          $signed({{24{master_step_in[7]}}, master_step_in}) *
          $signed({{16{num_in[15]}}, num_in});
    quo = acc / den_w;
    if ((acc % den_w) < 0)
    begin
      quo = quo - 32'sd1;
    end
  end

  // Remainder stays in [0, B) so no counts are lost unless a new B falls to or below it
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      rem_r <= 32'sd0;
      slave_step_out <= 16'sh0000;
    end
    else
    begin
      rem_r <= acc - quo * den_w;
      slave_step_out <= quo[15:0];
    end
  end

endmodule

// *** verilog/fgr_follower_axis.v ***
/*
  Follower axis gearing: master source select, engage with optional
  trigger edge and ramp, A/B scaling, sum with commanded motion, aux
  encoder tracking with rollover, velocity and motionless home cycle.
  Assumes encoder, marker, home and control inputs are asynchronous pins;
  commanded step, internal and analog velocity come from this clock.
*/
`timescale 1ns/10ps
`include "fgr_defines.vh"

module fgr_follower_axis
#(
  parameter IS_FIRST_AXIS = 1,
  parameter VEL_WINDOW = `FGR_VEL_WINDOW_CYC
)
(
  input wire sys_clk_in,                 // 20 MHz clock
  input wire rst_b_in,                   // Sync reset, active low
  input wire enc_a_in,                   // Aux encoder phase A pin
  input wire enc_b_in,                   // Aux encoder phase B pin
  input wire enc_marker_in,              // Aux encoder marker pin
  input wire home_switch_in,             // Home switch pin
  input wire [15:0] control_in,          // Control inputs first..sixteenth
  input wire signed [7:0] second_servo_step_in, // Second servo counts
  input wire signed [7:0] internal_step_in,  // Internal generator counts
  input wire signed [7:0] analog_step_in,    // Analog-derived counts
  input wire signed [15:0] cmd_step_in,  // Jog/move/program step
  input wire [1:0] master_source_in,     // Master source select
  input wire internal_select_in,         // Internal master select bit
  input wire engage_in,                  // Enable follower command
  input wire trigger_enable_in,          // External trigger configured
  input wire [3:0] trigger_select_in,    // Trigger input index
  input wire ramp_mode_in,               // Ramped follower mode
  input wire scurve_in,                  // S-curve ramp shaping
  input wire [15:0] jog_accel_in,        // Ramp step, 8 fraction bits
  input wire ratio_load_in,              // Ratio update strobe
  input wire signed [15:0] ratio_num_in, // New A
  input wire signed [15:0] ratio_den_in, // New B
  input wire home_start_in,              // Start aux home cycle
  input wire signed [31:0] home_pos_in,  // Configured home position
  input wire signed [31:0] high_limit_in,    // High count limit
  input wire signed [31:0] low_limit_in,     // Low count limit
  output reg signed [15:0] axis_step_out,    // Total axis step
  output reg signed [31:0] aux_pos_out,  // Aux encoder position
  output reg signed [31:0] aux_vel_out,  // Counts per window
  output reg homed_out,                  // Aux position valid
  output reg home_busy_out,              // Home cycle running
  output reg following_out,              // Follower engaged
  output reg ratio_err_out               // Rejected ratio, sticky
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [15:0] ctl_s1_r;
  reg [15:0] ctl_s2_r;
  reg [1:0] ab_prev_r;
  reg marker_prev_r;
  reg trig_prev_r;

  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      ctl_s1_r <= 16'h0000;
      ctl_s2_r <= 16'h0000;
    end
    else
    begin
      pin_s1_r <= {home_switch_in, enc_marker_in, enc_b_in, enc_a_in};
      pin_s2_r <= pin_s1_r;
      ctl_s1_r <= control_in;
      ctl_s2_r <= ctl_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decode
  // ----------------------------------------------------------------
  function signed [7:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 8'sh01;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = -8'sh01;
        default: quad_step = 8'sh00;
      endcase
    end
  endfunction

  wire signed [7:0] enc_step = quad_step(ab_prev_r, pin_s2_r[1:0]);
  wire signed [31:0] enc_step_ext = {{24{enc_step[7]}}, enc_step};
  wire marker_rise = pin_s2_r[2] & ~marker_prev_r;
  wire trig_now = ctl_s2_r[trigger_select_in];

  // ----------------------------------------------------------------
  // Master source selection
  // ----------------------------------------------------------------
  reg signed [7:0] master_step;

  always @*
  begin
    case (master_source_in)
      `FGR_SRC_AUX_OR_INT:
        master_step = internal_select_in ? internal_step_in
                                         : enc_step;
      `FGR_SRC_ANALOG: master_step = analog_step_in;
      `FGR_SRC_SECOND_SERVO:
        master_step = (IS_FIRST_AXIS != 0) ? second_servo_step_in
                                           : 8'sh00;
      default: master_step = 8'sh00;
    endcase
  end

  // ----------------------------------------------------------------
  // Ratio check and storage
  // ----------------------------------------------------------------
  reg signed [15:0] num_r;
  reg signed [15:0] den_r;
  wire signed [31:0] abs_num = ratio_num_in < 0 ?
    -{{16{ratio_num_in[15]}}, ratio_num_in} :
    {{16{ratio_num_in[15]}}, ratio_num_in};
  wire signed [31:0] den_ext = {{16{ratio_den_in[15]}}, ratio_den_in};
  wire ratio_ok = (den_ext > 0) &&
    (abs_num <= `FGR_RATIO_MAX_NUM * den_ext) &&
    ((abs_num == 0) || (abs_num * `FGR_RATIO_MIN_DEN >= den_ext));

  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      num_r <= 16'sh0001;
      den_r <= 16'sh0001;
      ratio_err_out <= 1'b0;
    end
    else if (ratio_load_in)
    begin
      if (ratio_ok)
      begin
        num_r <= ratio_num_in;
        den_r <= ratio_den_in;
      end
      else
      begin
        ratio_err_out <= 1'b1;           // Keep old ratio
      end
    end
  end

  // ----------------------------------------------------------------
  // Scaler
  // ----------------------------------------------------------------
  wire signed [15:0] scaled_step;

  fgr_ratio_scaler u_scaler
  (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .master_step_in(following_out ? master_step : 8'sh00),
    .num_in(num_r),
    .den_in(den_r),
    .slave_step_out(scaled_step)
  );

  // ----------------------------------------------------------------
  // Engage state machine
  // ----------------------------------------------------------------
  reg [1:0] eng_r;
  reg [1:0] eng_nxt;

  always @*
  begin
    eng_nxt = eng_r;
    case (eng_r)
      `FGR_ENG_OFF:
        if (engage_in)
          eng_nxt = trigger_enable_in ? `FGR_ENG_ARMED
                                      : `FGR_ENG_ON;
      `FGR_ENG_ARMED:
        if (!engage_in)
          eng_nxt = `FGR_ENG_OFF;
        else if (trig_now && !trig_prev_r)
          eng_nxt = `FGR_ENG_ON;
      `FGR_ENG_ON:
        if (!engage_in)
          eng_nxt = `FGR_ENG_OFF;
      default: eng_nxt = `FGR_ENG_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // Ramp toward scaled velocity at jog rate
  // ----------------------------------------------------------------
  reg signed [31:0] ramp_vel_r;
  reg signed [31:0] ramp_frac_r;
  reg ramp_half_r;
  wire signed [31:0] target = {{16{scaled_step[15]}}, scaled_step}
                              <<< `FGR_RAMP_FRAC;
  wire signed [31:0] rate = {16'h0000, jog_accel_in};
  // S-curve advances every other cycle: twice the linear time
  wire ramp_tick = !scurve_in || ramp_half_r;
  reg signed [31:0] ramp_nxt;

  always @*
  begin
    ramp_nxt = ramp_vel_r;
    if (ramp_tick)
    begin
      if (target > ramp_vel_r + rate)
        ramp_nxt = ramp_vel_r + rate;
      else if (target < ramp_vel_r - rate)
        ramp_nxt = ramp_vel_r - rate;
      else
        ramp_nxt = target;
    end
  end

  // Whole counts from the ramped velocity with fraction carried
  wire signed [31:0] ramp_sum = ramp_frac_r + ramp_vel_r;
  wire signed [31:0] ramp_whole = ramp_sum >>> `FGR_RAMP_FRAC;
  wire signed [15:0] follow_step = ramp_mode_in ? ramp_whole[15:0]
                                                : scaled_step;

  // ----------------------------------------------------------------
  // Aux encoder position with rollover
  // ----------------------------------------------------------------
  reg home_r;
  wire signed [31:0] pos_inc = aux_pos_out +
                               {{24{enc_step[7]}}, enc_step};
  wire home_hit = home_r && marker_rise && pin_s2_r[3];
  reg signed [31:0] pos_nxt;

  always @*
  begin
    if (home_hit)
      pos_nxt = home_pos_in;
    else if (enc_step > 0 && aux_pos_out >= high_limit_in)
      pos_nxt = low_limit_in;
    else if (enc_step < 0 && aux_pos_out <= low_limit_in)
      pos_nxt = high_limit_in;
    else
      pos_nxt = pos_inc;
  end

  // ----------------------------------------------------------------
  // Velocity window counter
  // ----------------------------------------------------------------
  reg [31:0] win_cnt_r;
  reg signed [31:0] win_acc_r;

  // ----------------------------------------------------------------
  // State registers and outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ab_prev_r <= 2'h0;
      marker_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
      eng_r <= `FGR_ENG_OFF;
      following_out <= 1'b0;
      ramp_vel_r <= 32'sd0;
      ramp_frac_r <= 32'sd0;
      ramp_half_r <= 1'b0;
      axis_step_out <= 16'sh0000;
      aux_pos_out <= 32'sd0;
      aux_vel_out <= 32'sd0;
      win_cnt_r <= 32'h00000000;
      win_acc_r <= 32'sd0;
      home_r <= `FGR_HOME_IDLE;
      home_busy_out <= 1'b0;
      homed_out <= 1'b0;
    end
    else
    begin
      ab_prev_r <= pin_s2_r[1:0];
      marker_prev_r <= pin_s2_r[2];
      trig_prev_r <= trig_now;
      eng_r <= eng_nxt;
      following_out <= (eng_nxt == `FGR_ENG_ON);
      ramp_half_r <= ~ramp_half_r;
      ramp_vel_r <= ramp_nxt;
      ramp_frac_r <= ramp_sum - (ramp_whole <<< `FGR_RAMP_FRAC);
      // Home cycle contributes nothing to the axis step
      axis_step_out <= follow_step + cmd_step_in;
      aux_pos_out <= pos_nxt;
      if (win_cnt_r >= VEL_WINDOW - 1)
      begin
        win_cnt_r <= 32'h00000000;
        aux_vel_out <= win_acc_r + enc_step_ext;
        win_acc_r <= 32'sd0;
      end
      else
      begin
        win_cnt_r <= win_cnt_r + 32'h00000001;
        win_acc_r <= win_acc_r + enc_step_ext;
      end
      if (home_hit)
      begin
        home_r <= `FGR_HOME_IDLE;
        home_busy_out <= 1'b0;
        homed_out <= 1'b1;
      end
      else if (home_start_in)
      begin
        home_r <= `FGR_HOME_WAIT;
        home_busy_out <= 1'b1;
      end
    end
  end

endmodule

// *** bench/fgr_axis_chk_assertions.sv ***
/*
  Checker for the follower gearing axis: engage, trigger, ratio
  refusal, home cycle and commanded-only step.
  Assumes binding to fgr_follower_axis and sight of its ports only.
*/
`timescale 1ns/10ps
module fgr_axis_chk
(
  input wire sys_clk_in, // Clock
  input wire rst_b_in, // Sync reset
  input wire [15:0] control_in, // Control inputs
  input wire signed [15:0] cmd_step_in, // Commanded step
  input wire engage_in, // Engage
  input wire trigger_enable_in, // Trigger on
  input wire [3:0] trigger_select_in, // Trigger index
  input wire ramp_mode_in, // Ramp mode
  input wire ratio_load_in, // Ratio strobe
  input wire signed [15:0] ratio_num_in, // A
  input wire signed [15:0] ratio_den_in, // B
  input wire home_start_in, // Home start
  input wire signed [31:0] home_pos_in, // Home position
  input wire signed [15:0] axis_step_out, // Axis step
  input wire signed [31:0] aux_pos_out, // Aux position
  input wire homed_out, // Homed flag
  input wire home_busy_out, // Home busy
  input wire following_out, // Following
  input wire ratio_err_out // Ratio error
);
  // -----------------------------------------------------------
  // Ratio legality
  // -----------------------------------------------------------
  wire signed [31:0] a_s = ratio_num_in;
  wire signed [31:0] b_s = ratio_den_in;
  wire signed [31:0] a_mag = (a_s < 0) ? -a_s : a_s;
  // B not positive, above 32:1 or below 1:10000
  wire bad_ratio = (b_s <= 0) || (a_mag > 32'sh20 * b_s) ||
    ((a_mag != 0) && (a_mag * 32'sh2710 < b_s));
  default clocking cb @(posedge sys_clk_in);
  endclocking
  // Low until one edge has passed with reset released
  reg rst_seen_r = 1'b0;
  always @(posedge sys_clk_in)
    rst_seen_r <= rst_b_in;
  default disable iff (!rst_b_in || !rst_seen_r);
  AST_ENGAGE: assert property (
    engage_in && !trigger_enable_in && !following_out |=> following_out)
    else $error("engage did not start following");
  AST_DISENGAGE: assert property (
    !engage_in |=> !following_out)
    else $error("following without engage");
  AST_TRIG_WAIT: assert property (
    (trigger_enable_in && !following_out && $stable(trigger_select_in) &&
    !control_in[trigger_select_in]) [*4] |=> !following_out)
    else $error("following began without trigger edge");
  AST_RATIO_BAD: assert property (
    ratio_load_in && bad_ratio |=> ratio_err_out)
    else $error("bad ratio not flagged");
  AST_RATIO_GOOD: assert property (
    ratio_load_in && !bad_ratio && !ratio_err_out |=> !ratio_err_out)
    else $error("good ratio flagged");
  AST_ERR_STICKY: assert property (
    ratio_err_out |=> ratio_err_out)
    else $error("ratio error cleared");
  AST_HOME_START: assert property (
    home_start_in && !home_busy_out |=> home_busy_out)
    else $error("home cycle not started");
  AST_HOME_LOAD: assert property (
    $fell(home_busy_out) |-> homed_out && aux_pos_out == home_pos_in)
    else $error("home end without position load");
  AST_HOMED_STICKY: assert property (
    homed_out |=> homed_out)
    else $error("homed flag cleared");
  AST_CMD_ONLY: assert property (
    (!following_out && !ramp_mode_in) [*3] |->
    axis_step_out == $past(cmd_step_in))
    else $error("axis step differs from commanded step");
endmodule
bind fgr_follower_axis fgr_axis_chk i_fgr_axis_chk
(
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .control_in(control_in),
  .cmd_step_in(cmd_step_in), .engage_in(engage_in),
  .trigger_enable_in(trigger_enable_in),
  .trigger_select_in(trigger_select_in), .ramp_mode_in(ramp_mode_in),
  .ratio_load_in(ratio_load_in), .ratio_num_in(ratio_num_in),
  .ratio_den_in(ratio_den_in), .home_start_in(home_start_in),
  .home_pos_in(home_pos_in), .axis_step_out(axis_step_out),
  .aux_pos_out(aux_pos_out), .homed_out(homed_out),
  .home_busy_out(home_busy_out), .following_out(following_out),
  .ratio_err_out(ratio_err_out)
);

// *** bench/fgr_quad_enc_model.sv ***
/*
  Quadrature encoder model for the aux master input, with marker.
  Assumes the bench clock; one count per two cycles while run is high.
*/
`timescale 1ns/10ps
module fgr_quad_enc_model
(
  input wire clk_in, // Bench clock
  input wire run_in, // Count while high
  input wire dir_in, // High counts up
  input wire mark_in, // Marker request
  output reg enc_a_out = 1'b0, // Phase A
  output reg enc_b_out = 1'b0, // Phase B
  output reg marker_out = 1'b0 // Marker pulse
);
  reg ph = 1'b0;
  reg [1:0] mk = 2'h0;
  // Step the phases every other cycle, A leads when counting up
  always @(posedge clk_in)
  begin
    ph <= run_in & ~ph;
    if (run_in & ph)
    begin
      enc_a_out <= dir_in ? ~enc_b_out : enc_b_out;
      enc_b_out <= dir_in ? enc_a_out : ~enc_a_out;
    end
    mk <= mark_in ? 2'h3 : mk - {1'b0, |mk};
    marker_out <= mark_in | (|mk);
  end
endmodule

// *** bench/fgr_follower_axis_tb.sv ***
/*
  Self-checking bench for the follower gearing axis.
  Assumes the checker is bound and the velocity window is cut to 16.
*/
`timescale 1ns/10ps
module fgr_follower_axis_tb;
  reg clk = 1'b0, rst_b = 1'b0, run = 1'b0, dir = 1'b0, mark = 1'b0;
  reg hsw = 1'b0, isel = 1'b0, eng = 1'b0, trg_en = 1'b0, ramp = 1'b0;
  reg scurve = 1'b0, rl = 1'b0, hstart = 1'b0;
  reg [15:0] ctl = 16'h0, accel = 16'h0;
  reg [1:0] src = 2'h0;
  reg [3:0] trg_sel = 4'h0;
  reg signed [7:0] ss = 8'h0, in_st = 8'h0, an_st = 8'h0;
  reg signed [15:0] cmd = 16'h0, rn = 16'h1, rd = 16'h1;
  reg signed [31:0] hpos = 32'h0, hlim = 32'h2d, llim = -32'sh5;
  wire enc_a, enc_b, marker, homed, busy, foll, err;
  wire signed [15:0] axis_step;
  wire signed [31:0] aux_pos, aux_vel;
  reg signed [31:0] meas, pexp;
  reg [31:0] r = 32'h3145, want, got;
  reg [7:0] e;
  integer n_fail = 0, checks_done = 0, k, t1, t2;
  integer sel_q[$];
  reg [31:0] exp_q[$];
  localparam logic [63:0] RT [0:3] = '{64'hfffd_0001_0005_0064,
    64'h0020_0001_fffc_0064, 64'h8000_0400_0001_0000,
    64'h0001_0001_0007_fff7};
  localparam logic [31:0] BAD [0:3] = '{32'h0021_0001, 32'h0001_2711,
    32'h0005_0000, 32'h0001_fffe};

  // Clock, 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end

  fgr_quad_enc_model i_fgr_quad_enc_model (.clk_in(clk), .run_in(run),
    .dir_in(dir), .mark_in(mark), .enc_a_out(enc_a), .enc_b_out(enc_b),
    .marker_out(marker));

  fgr_follower_axis #(.IS_FIRST_AXIS(1), .VEL_WINDOW(16))
    i_fgr_follower_axis (.sys_clk_in(clk), .rst_b_in(rst_b),
    .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_marker_in(marker),
    .home_switch_in(hsw), .control_in(ctl), .second_servo_step_in(ss),
    .internal_step_in(in_st), .analog_step_in(an_st), .cmd_step_in(cmd),
    .master_source_in(src), .internal_select_in(isel), .engage_in(eng),
    .trigger_enable_in(trg_en), .trigger_select_in(trg_sel),
    .ramp_mode_in(ramp), .scurve_in(scurve), .jog_accel_in(accel),
    .ratio_load_in(rl), .ratio_num_in(rn), .ratio_den_in(rd),
    .home_start_in(hstart), .home_pos_in(hpos), .high_limit_in(hlim),
    .low_limit_in(llim), .axis_step_out(axis_step), .aux_pos_out(aux_pos),
    .aux_vel_out(aux_vel), .homed_out(homed), .home_busy_out(busy),
    .following_out(foll), .ratio_err_out(err));

  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected position after n counts with wrap at 45 and -5
  function integer roll(input integer p, input integer d, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        p = d ? ((p >= 45) ? -5 : p + 1) : ((p <= -5) ? 45 : p - 1);
      roll = p;
    end
  endfunction
  function [31:0] obs(input integer s);
    case (s)
      0: obs = {{16{axis_step[15]}}, axis_step};
      1: obs = aux_pos;
      2: obs = aux_vel;
      3: obs = {28'h0, homed, busy, foll, err};
      default: obs = meas;
    endcase
  endfunction
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input integer s, input [31:0] x);
    begin
      sel_q.push_back(s);
      exp_q.push_back(x);
    end
  endtask
  task do_reset;
    begin
      rst_b <= 1'b0;
      tick(6);
      rst_b <= 1'b1;
      tick(1);
    end
  endtask
  task load(input [15:0] a, input [15:0] b);
    begin
      rl <= 1'b1;
      rn <= a;
      rd <= b;
      tick(1);
      rl <= 1'b0;
      tick(1);
    end
  endtask
  // Run the encoder n counts, check window velocity before stopping
  task enc_run(input reg d, input integer n);
    begin
      dir <= d;
      run <= 1'b1;
      tick(2 * n);
      chk(2, d ? 32'h8 : -32'sh8);
      run <= 1'b0;
      tick(6);
    end
  endtask
  // Cycles spent between one and seven counts while the ramp climbs
  task ramp_time(input reg sc, output integer t);
    integer n;
    begin
      eng <= 1'b0;
      scurve <= sc;
      tick(100);
      eng <= 1'b1;
      t = 0;
      for (n = 0; n < 300 && axis_step !== 16'sh8; n = n + 1)
      begin
        @(negedge clk);
        if (axis_step > 16'sh0 && axis_step < 16'sh8)
          t = t + 1;
      end
      if (n == 300)
      begin
        n_fail = n_fail + 1;
        results;
      end
      tick(1);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Compare each noted expectation with the output it names
  always @(negedge clk)
    while (exp_q.size() > 0)
    begin
      want = exp_q.pop_front();
      got = obs(sel_q.pop_front());
      checks_done = checks_done + 1;
      if (got !== want)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t want %h got %h", $time, want, got);
      end
    end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial
  begin
    r = lfsr(r);
    hpos <= r;
    do_reset;
    chk(3, 32'h0);
    eng <= 1'b1;
    for (k = 0; k < 5; k = k + 1)
    begin
      r = lfsr(r);
      ss <= r[7:0];
      in_st <= r[15:8];
      an_st <= r[23:16];
      src <= (k == 4) ? 2'h0 : k[1:0];
      isel <= (k == 0);
      tick(6);
      e = (k == 0) ? r[15:8] : (k == 1) ? r[23:16] : (k == 2) ? r[7:0] : 0;
      chk(0, {{24{e[7]}}, e});
      chk(3, 32'h2);
    end
    $display("test sources done");
    src <= 2'h2; // Second servo feeds the ratio tests
    for (k = 0; k < 4; k = k + 1)
    begin
      load(RT[k][63:48], RT[k][47:32]);
      ss <= RT[k][23:16];
      cmd <= RT[k][15:0];
      tick(6);
      meas = $signed(RT[k][63:48]) * $signed(RT[k][31:16]);
      chk(0, meas / $signed(RT[k][47:32]) + $signed(RT[k][15:0]));
      chk(3, 32'h2);
    end
    $display("test ratios done");
    load(16'h1, 16'h3);
    ss <= 8'sh1;
    cmd <= 16'h0;
    tick(6);
    meas = 0;
    repeat (30)
    begin
      @(negedge clk);
      meas = meas + axis_step;
    end
    chk(4, 32'ha);
    tick(1);
    $display("test remainder done");
    eng <= 1'b0;
    trg_en <= 1'b1;
    tick(3);
    for (k = 0; k < 16; k = k + 1)
    begin
      trg_sel <= k[3:0];
      ctl <= ~(16'h1 << k);
      eng <= 1'b1;
      tick(8);
      chk(3, 32'h0);
      ctl <= 16'hffff;
      tick(6);
      chk(3, 32'h2);
      eng <= 1'b0;
      ctl <= 16'h0;
      tick(3);
    end
    trg_en <= 1'b0;
    $display("test trigger done");
    load(16'h1, 16'h1);
    ss <= 8'sh8;
    ramp <= 1'b1;
    accel <= 16'h0100; // One count per ramp tick: each cycle linear, every other cycle with S-curve
    ramp_time(1'b0, t1);
    ramp_time(1'b1, t2);
    // Levels one to seven once each, held twice as long with S-curve
    meas = {t1 == 7, t2 == 14};
    chk(4, 32'h3);
    eng <= 1'b0;
    ramp <= 1'b0;
    $display("test ramp done");
    enc_run(1'b1, 50);
    pexp = roll(0, 1, 50);
    chk(1, pexp);
    enc_run(1'b0, 20);
    pexp = roll(pexp, 0, 20);
    chk(1, pexp);
    tick(40);
    chk(2, 32'h0);
    $display("test encoder done");
    cmd <= 16'sh4d;
    hstart <= 1'b1;
    tick(1);
    hstart <= 1'b0;
    tick(2);
    chk(3, 32'h4);
    mark <= 1'b1;
    tick(1);
    mark <= 1'b0;
    tick(8);
    chk(1, pexp);
    hsw <= 1'b1;
    mark <= 1'b1;
    tick(1);
    mark <= 1'b0;
    tick(8);
    chk(3, 32'h8);
    chk(1, hpos);
    chk(0, 32'h4d);
    cmd <= 16'h0;
    $display("test home done");
    src <= 2'h2;
    ss <= 8'sh3;
    for (k = 0; k < 4; k = k + 1)
    begin
      do_reset;
      eng <= 1'b1;
      load(BAD[k][31:16], BAD[k][15:0]);
      tick(5);
      chk(3, 32'h3);
      chk(0, 32'h3);
    end
    $display("test bad ratio done");
    tick(2);
    results;
  end
endmodule
